// *** rtl/pwes_wake_status.v ***
/*
  Wake event status block: global wake flag and enable, three banks of
  sticky per-source status bits with enables, and the active-low wake
  output. Assumes resetn is the standby-power reset only; main-power,
  soft and hard resets are not connected here so state survives them.
  Host accesses arrive as one-cycle read and write strobes on a byte
  offset already decoded to this block's I/O base.
*/
`timescale 1ns/1ps
`include "pwes_regs.vh"

module pwes_wake_status (
  sys_clk,
  resetn,
  hostAddr,
  hostWrData,
  hostWrStrobe,
  hostRdStrobe,
  hostRdData,
  hostRdValid,
  ringIndicatorA,
  ringIndicatorB,
  keyboardWake,
  mouseWake,
  specificKeyWake,
  fanSpeedSenseA,
  fanSpeedSenseB,
  gpioPinBank2,
  gpioPin20to22,
  gpioPin24to27,
  groupedDeviceIrqStatus,
  wakeOutN
);
  input wire sys_clk;
  input wire resetn;
  input wire [7:0] hostAddr;
  input wire [7:0] hostWrData;
  input wire hostWrStrobe;
  input wire hostRdStrobe;
  output reg [7:0] hostRdData;
  output reg hostRdValid;
  input wire ringIndicatorA;
  input wire ringIndicatorB;
  input wire keyboardWake;
  input wire mouseWake;
  input wire specificKeyWake;
  input wire fanSpeedSenseA;
  input wire fanSpeedSenseB;
  input wire [7:0] gpioPinBank2;
  input wire [2:0] gpioPin20to22;
  input wire [3:0] gpioPin24to27;
  input wire groupedDeviceIrqStatus;
  output reg wakeOutN;

  reg wakeGlobalFlag_q;
  reg wakeGlobalFlag_d;
  reg wakeEnableBit_q;
  reg [23:0] srcStatus_q;
  reg [23:0] srcStatus_d;
  reg [23:0] srcEnable_q;
  reg [7:0] rdMux;
  wire [23:0] srcLevel;
  wire [23:0] srcRise;
  wire [23:0] wrClearMask;
  wire wrGlobalStatus;
  wire wrGlobalEnable;
  wire wakeRequest;

  // Pack sources into bank order; bank 1 bit 0 is tied low
  assign srcLevel[0] = 1'b0;
  assign srcLevel[1] = ringIndicatorB;
  assign srcLevel[2] = ringIndicatorA;
  assign srcLevel[3] = keyboardWake;
  assign srcLevel[4] = mouseWake;
  assign srcLevel[5] = specificKeyWake;
  assign srcLevel[6] = fanSpeedSenseA;
  assign srcLevel[7] = fanSpeedSenseB;
  assign srcLevel[15:8] = gpioPinBank2;
  assign srcLevel[18:16] = gpioPin20to22;
  assign srcLevel[19] = groupedDeviceIrqStatus;
  assign srcLevel[23:20] = gpioPin24to27;

  // Pins are asynchronous, so sync and turn into one-cycle events
  pwes_edge_detect uEdge (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .srcLevel(srcLevel),
    .srcRise(srcRise)
  );

  // Write decode
  assign wrGlobalStatus = hostWrStrobe && (hostAddr == `PWES_OFF_GLOBAL_STATUS);
  assign wrGlobalEnable = hostWrStrobe && (hostAddr == `PWES_OFF_GLOBAL_ENABLE);

  // One-to-clear masks per bank; zeros leave bits alone
  assign wrClearMask[7:0] = (hostWrStrobe && hostAddr == `PWES_OFF_SRC_BANK1) ?
    hostWrData : 8'h00;
  assign wrClearMask[15:8] = (hostWrStrobe && hostAddr == `PWES_OFF_SRC_BANK2) ?
    hostWrData : 8'h00;
  assign wrClearMask[23:16] = (hostWrStrobe && hostAddr == `PWES_OFF_SRC_BANK3) ?
    hostWrData : 8'h00;

  // Any enabled, pending source asks for a wake
  assign wakeRequest = |(srcStatus_q & srcEnable_q);

  // Sticky source bits: an event in the clear cycle wins
  always @* begin
    srcStatus_d = (srcStatus_q & ~wrClearMask) | srcRise;
    srcStatus_d[0] = 1'b0;
  end

  // Global flag tracks would-assert regardless of global enable
  always @* begin
    wakeGlobalFlag_d = wakeGlobalFlag_q;
    if (wrGlobalStatus && hostWrData[`PWES_GLOBAL_FLAG_BIT]) begin
      wakeGlobalFlag_d = 1'b0;
    end
    // Set is checked last so it beats a clear in the same cycle
    if (wakeRequest) begin
      wakeGlobalFlag_d = 1'b1;
    end
  end

  // Only standby-power reset reaches these flops
  always @(posedge sys_clk) begin
    if (!resetn) begin
      wakeGlobalFlag_q <= 1'b0;
      wakeEnableBit_q <= 1'b0;
      srcStatus_q <= 24'h00_0000;
      srcEnable_q <= 24'h00_0000;
    end else begin
      wakeGlobalFlag_q <= wakeGlobalFlag_d;
      srcStatus_q <= srcStatus_d;
      if (wrGlobalEnable) begin
        wakeEnableBit_q <= hostWrData[`PWES_GLOBAL_EN_BIT];
      end
      if (hostWrStrobe && hostAddr == `PWES_OFF_EN_BANK1) begin
        srcEnable_q[7:0] <= hostWrData & `PWES_BANK1_VALID_MASK;
      end
      if (hostWrStrobe && hostAddr == `PWES_OFF_EN_BANK2) begin
        srcEnable_q[15:8] <= hostWrData;
      end
      if (hostWrStrobe && hostAddr == `PWES_OFF_EN_BANK3) begin
        srcEnable_q[23:16] <= hostWrData;
      end
    end
  end

  // Read mux; reserved bits and offsets read zero
  always @* begin
    case (hostAddr)
      `PWES_OFF_GLOBAL_STATUS: rdMux = {7'h00, wakeGlobalFlag_q};
      `PWES_OFF_GLOBAL_ENABLE: rdMux = {7'h00, wakeEnableBit_q};
      `PWES_OFF_SRC_BANK1: rdMux = srcStatus_q[7:0];
      `PWES_OFF_SRC_BANK2: rdMux = srcStatus_q[15:8];
      `PWES_OFF_SRC_BANK3: rdMux = srcStatus_q[23:16];
      `PWES_OFF_EN_BANK1: rdMux = srcEnable_q[7:0];
      `PWES_OFF_EN_BANK2: rdMux = srcEnable_q[15:8];
      `PWES_OFF_EN_BANK3: rdMux = srcEnable_q[23:16];
      default: rdMux = 8'h00;
    endcase
  end

  // Registered outputs; wake follows flag and enable one cycle later
  always @(posedge sys_clk) begin
    if (!resetn) begin
      hostRdData <= 8'h00;
      hostRdValid <= 1'b0;
      wakeOutN <= 1'b1;
    end else begin
      hostRdValid <= hostRdStrobe;
      hostRdData <= hostRdStrobe ? rdMux : 8'h00;
      wakeOutN <= ~(wakeEnableBit_q & wakeGlobalFlag_q);
    end
  end
endmodule

// *** shared/pwes_regs.vh ***
/*
  Register offsets, field positions and reset values for the wake
  event status block. Assumes byte-wide registers at offsets from an
  I/O base decoded by the host bus front end.
*/
`ifndef PWES_REGS_VH
`define PWES_REGS_VH

`define PWES_OFF_GLOBAL_STATUS 8'h00
`define PWES_OFF_RSVD_01 8'h01
`define PWES_OFF_GLOBAL_ENABLE 8'h02
`define PWES_OFF_RSVD_03 8'h03
`define PWES_OFF_SRC_BANK1 8'h04
`define PWES_OFF_SRC_BANK2 8'h05
`define PWES_OFF_SRC_BANK3 8'h06
`define PWES_OFF_EN_BANK1 8'h0A
`define PWES_OFF_EN_BANK2 8'h0B
`define PWES_OFF_EN_BANK3 8'h0C

`define PWES_GLOBAL_FLAG_BIT 0
`define PWES_GLOBAL_EN_BIT 0
`define PWES_RESET_VALUE 8'h00
`define PWES_BANK1_VALID_MASK 8'hFE
`define PWES_SYNC_STAGES 2

`endif

// *** rtl/pwes_edge_detect.v ***
/*
  Per-bit two-flop synchroniser and rising-edge detector for the wake
  sources. Assumes source levels arrive asynchronously from pins.
*/
`timescale 1ns/1ps
`include "pwes_regs.vh"

module pwes_edge_detect (
  sys_clk,
  resetn,
  srcLevel,
  srcRise
);
  input wire sys_clk;
  input wire resetn;
  input wire [23:0] srcLevel;
  output reg [23:0] srcRise;

  reg [23:0] syncA_q;
  reg [23:0] syncB_q;
  reg [23:0] prev_q;

  // Stage one feeds stage two only; edge logic looks at stage two
  always @(posedge sys_clk) begin
    if (!resetn) begin
      syncA_q <= 24'h00_0000;
      syncB_q <= 24'h00_0000;
      prev_q <= 24'h00_0000;
      srcRise <= 24'h00_0000;
    end else begin
      syncA_q <= srcLevel;
      syncB_q <= syncA_q;
      prev_q <= syncB_q;
      srcRise <= syncB_q & ~prev_q;
    end
  end
endmodule

// *** verif/pwes_wake_status_checker.sv ***
/* Port assertions for the wake status block.
   Assumes one clock and the synchronous active-low standby reset. */
`timescale 1ns/1ps
module pwes_wake_status_checker (
  input wire sys_clk,
  input wire resetn,
  input wire [7:0] hostAddr,
  input wire [7:0] hostWrData,
  input wire hostWrStrobe,
  input wire hostRdStrobe,
  input wire [7:0] hostRdData,
  input wire hostRdValid,
  input wire wakeOutN
);
  reg enQ_q;
  // Shadow of the global enable, rebuilt from host writes
  always @(posedge sys_clk) begin
    if (!resetn) enQ_q <= 1'b0;
    else if (hostWrStrobe && hostAddr == 8'h02) enQ_q <= hostWrData[0];
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_en_off;
    hostWrStrobe && hostAddr == 8'h02 && !hostWrData[0];
  endsequence
  a_rsvd_reads_zero: assert property (hostRdStrobe && hostAddr[7:2] == 6'h00 && hostAddr[0]
    |=> hostRdValid && hostRdData == 8'h00) else $error("reserved offset read nonzero");
  a_global_upper_zero: assert property (hostRdStrobe && hostAddr[7:2] == 6'h00
    |=> hostRdValid && hostRdData[7:1] == 7'h00) else $error("reserved global bits set");
  a_bank1_bit0_zero: assert property (hostRdStrobe && hostAddr == 8'h04
    |=> hostRdData[0] == 1'b0) else $error("bank1 bit0 set");
  a_read_one_pulse: assert property (hostRdValid == $past(hostRdStrobe))
    else $error("read valid not one cycle after strobe");
  a_idle_data_zero: assert property (!hostRdValid |-> hostRdData == 8'h00)
    else $error("read data nonzero outside valid");
  a_disable_releases: assert property (s_en_off |=> ##1 wakeOutN)
    else $error("wake held after global disable");
  a_wake_needs_en: assert property (!wakeOutN |-> $past(enQ_q))
    else $error("wake asserted without global enable");
  a_wake_stays_low: assert property (!wakeOutN && !$past(hostWrStrobe) |=> !wakeOutN)
    else $error("wake released without host write");
endmodule
bind pwes_wake_status pwes_wake_status_checker chk_u (.sys_clk, .resetn, .hostAddr,
  .hostWrData, .hostWrStrobe, .hostRdStrobe, .hostRdData, .hostRdValid, .wakeOutN);

// *** verif/pwes_wake_rx.sv ***
/* System wake receiver: counts cycles with the wake line low.
   Assumes the wake line is registered on sys_clk. */
`timescale 1ns/1ps
module pwes_wake_rx (
  input wire sys_clk,
  input wire resetn,
  input wire wakeOutN,
  output reg [7:0] lowCnt_q
);
  // Saturating count so a long wake never wraps to zero
  always @(posedge sys_clk) begin
    if (!resetn) lowCnt_q <= 8'h00;
    else if (!wakeOutN && lowCnt_q != 8'hff) lowCnt_q <= lowCnt_q + 8'h01;
  end
endmodule

// *** verif/pwes_wake_status_tb.sv ***
/* Self-checking bench for the wake status block.
   Assumes pins map bank bits directly; pin[0] has no source. */
`timescale 1ns/1ps
module pwes_wake_status_tb;
  reg sys_clk = 0;
  reg resetn = 0;
  reg [7:0] hostAddr = 0;
  reg [7:0] hostWrData = 0;
  reg hostWrStrobe = 0;
  reg hostRdStrobe = 0;
  reg [23:0] pin = 0;
  reg [23:0] e;
  wire [7:0] hostRdData;
  wire [7:0] lowCnt;
  wire hostRdValid;
  wire wakeOutN;
  integer seed = 32'hbda5;
  integer errors = 0;
  integer compares = 0;
  integer k;
  integer b;
  // Free-running system clock
  always #25 sys_clk = ~sys_clk;
  pwes_wake_status dut_u (.sys_clk(sys_clk), .resetn(resetn), .hostAddr(hostAddr),
    .hostWrData(hostWrData), .hostWrStrobe(hostWrStrobe), .hostRdStrobe(hostRdStrobe),
    .hostRdData(hostRdData), .hostRdValid(hostRdValid), .ringIndicatorB(pin[1]),
    .ringIndicatorA(pin[2]), .keyboardWake(pin[3]), .mouseWake(pin[4]),
    .specificKeyWake(pin[5]), .fanSpeedSenseA(pin[6]), .fanSpeedSenseB(pin[7]),
    .gpioPinBank2(pin[15:8]), .gpioPin20to22(pin[18:16]),
    .groupedDeviceIrqStatus(pin[19]), .gpioPin24to27(pin[23:20]), .wakeOutN(wakeOutN));
  pwes_wake_rx rx_u (.sys_clk(sys_clk), .resetn(resetn), .wakeOutN(wakeOutN),
    .lowCnt_q(lowCnt));
  // Bank image of raised pins; bank1 bit0 has no source
  function [23:0] expv(input [23:0] p);
    expv = p & 24'hff_fffe;
  endfunction
  task finish_test;
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string n, input [7:0] x, input [7:0] g);
    compares = compares + 1;
    if (g !== x) begin
      $display("CHECK FAILED %s exp %h got %h", n, x, g);
      errors = errors + 1;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    hostAddr = a;
    hostWrData = d;
    hostWrStrobe = 1;
    @(posedge sys_clk) #1;
    hostWrStrobe = 0;
    // Idle edge so a following call never re-raises the strobe at once
    @(posedge sys_clk) #1;
  endtask
  // Read with a bounded wait for valid
  task rc(input [7:0] a, input [7:0] x);
    integer i;
    hostAddr = a;
    hostRdStrobe = 1;
    @(posedge sys_clk) #1;
    hostRdStrobe = 0;
    for (i = 0; i < 3 && hostRdValid !== 1'b1; i = i + 1) @(posedge sys_clk) #1;
    if (hostRdValid !== 1'b1) begin
      errors = errors + 1;
      finish_test;
    end
    chk($sformatf("reg %h", a), x, hostRdData);
    @(posedge sys_clk) #1;
  endtask
  task gap;
    repeat (8) @(posedge sys_clk) #1;
  endtask
  // Main sequence: reset values, reserved places, events, wake path
  initial begin
    gap;
    resetn = 1;
    for (k = 0; k < 7; k = k + 1) rc(k, 8'h00);
    wr(8'h01, 8'hff);
    wr(8'h03, 8'hff);
    wr(8'h00, 8'hff);
    wr(8'h02, 8'hff);
    rc(8'h01, 8'h00);
    rc(8'h02, 8'h01);
    rc(8'h00, 8'h00);
    wr(8'h02, 8'h00);
    for (k = 0; k < 5; k = k + 1) begin
      pin = (k == 0) ? 24'hff_ffff : $random(seed);
      e = expv(pin);
      gap;
      pin = 0;
      gap;
      chk("wake", 8'h01, {7'h00, wakeOutN});
      for (b = 0; b < 3; b = b + 1) begin
        rc(4 + b, e[8*b+:8]);
        wr(4 + b, 8'h00);
        rc(4 + b, e[8*b+:8]);
        wr(4 + b, 8'hff);
        rc(4 + b, 8'h00);
      end
    end
    wr(8'h0A, 8'hff);
    pin[3] = 1;
    gap;
    chk("wake", 8'h01, {7'h00, wakeOutN});
    rc(8'h00, 8'h01);
    wr(8'h02, 8'h01);
    gap;
    chk("wake", 8'h00, {7'h00, wakeOutN});
    wr(8'h04, 8'hff);
    wr(8'h00, 8'h00);
    rc(8'h00, 8'h01);
    wr(8'h00, 8'h01);
    gap;
    chk("wake", 8'h01, {7'h00, wakeOutN});
    rc(8'h00, 8'h00);
    chk("lowcnt", 8'h01, {7'h00, lowCnt > 8'h03});
    finish_test;
  end
endmodule
